/* src/paq_queue.sv */
`timescale 1ns/1ps
module paq_queue #(
   parameter int M_PORTS    = paq_pkg::M_PORTS_DEF,
   parameter int DATA_W     = paq_pkg::DATA_W_DEF,
   parameter int LEN_W      = paq_pkg::LEN_W_DEF,
   parameter int POOL_DEPTH = paq_pkg::POOL_DEPTH_DEF,
   parameter int PW         = (M_PORTS > 1) ? $clog2(M_PORTS) : 1,
   parameter int CW         = $clog2(POOL_DEPTH + paq_pkg::OBUF_ENTRIES + 1),
   parameter int FW         = $clog2(POOL_DEPTH + 1),
   parameter int AW         = (POOL_DEPTH > 1) ? $clog2(POOL_DEPTH) : 1,
   parameter int BW         = LEN_W + CW
) (
   input  wire logic                          clk,
   input  wire logic                          rst_n,
   input  wire logic [M_PORTS-1:0]            in_valid,
   output logic      [M_PORTS-1:0]            in_ready,
   input  wire logic [M_PORTS*DATA_W-1:0]     in_data,
   input  wire logic [M_PORTS*LEN_W-1:0]      in_len,
   input  wire logic [M_PORTS-1:0]            in_drop,
   output logic                               out_valid,
   input  wire logic                          out_ready,
   output logic      [DATA_W-1:0]             out_data,
   output logic      [LEN_W-1:0]              out_len,
   input  wire logic                          cfg_limit_en,
   input  wire logic [CW-1:0]                 cfg_limit_pkts,
   input  wire logic [CW-1:0]                 cfg_thresh_pkts,
   input  wire logic [BW-1:0]                 cfg_thresh_bytes,
   input  wire logic [FW-1:0]                 cfg_pool_thresh,
   output logic      [CW-1:0]                 depth_pkts,
   output logic      [BW-1:0]                 depth_bytes,
   output logic                               over_pkts,
   output logic                               over_bytes,
   output logic      [FW-1:0]                 pool_free,
   output logic                               pool_low,
   output logic                               pkts_avail,
   output logic                               tail_drop,
   output logic      [paq_pkg::CNT_PKT_W-1:0]  drop_pkts,
   output logic      [paq_pkg::CNT_BYTE_W-1:0] drop_bytes
);

   localparam int OB = paq_pkg::OBUF_ENTRIES;

   // next port in round-robin order that has a packet waiting
   function automatic logic [PW-1:0] next_port(
      input logic [M_PORTS-1:0] v,
      input logic [PW-1:0]      p
   );
      logic [PW-1:0] r;
      logic          found;
      int            idx;
      r     = PW'((int'(p) + 1) % M_PORTS);
      found = 1'b0;
      for (int k = 1; k <= M_PORTS; k++) begin
         idx = (int'(p) + k) % M_PORTS;
         if (!found && v[idx]) begin
            r     = PW'(idx);
            found = 1'b1;
         end
      end
      return r;
   endfunction

   // ---------------- multiplexor ----------------
   logic [PW-1:0]      rr_q;
   logic [M_PORTS-1:0] rdy_q;
   logic               accept;
   logic [PW-1:0]      rr_d;

   assign accept = in_valid[rr_q] & rdy_q[rr_q]; // R18
   assign rr_d   = next_port(accept ? (in_valid & ~(M_PORTS'(1) << rr_q))
                                    : in_valid, rr_q);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rr_q  <= '0;
         rdy_q <= '0;
      end else begin
         rr_q  <= rr_d; // R4
         rdy_q <= M_PORTS'(1) << rr_d; // R4
      end
   end

   assign in_ready = rdy_q;

   // ------- stage register, acts as the null action -------
   logic              st_valid_q;
   logic [DATA_W-1:0] st_data_q;
   logic [LEN_W-1:0]  st_len_q;
   logic              st_drop_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_valid_q <= paq_pkg::RST_VALID;
         st_data_q  <= '0;
         st_len_q   <= '0;
         st_drop_q  <= paq_pkg::RST_FLAG;
      end else begin
         st_valid_q <= accept;
         if (accept) begin
            st_data_q <= in_data[rr_q*DATA_W +: DATA_W]; // R6
            st_len_q  <= in_len[rr_q*LEN_W +: LEN_W]; // R6
            st_drop_q <= in_drop[rr_q];
         end
      end
   end

   // ---------------- counter and absolute dropper ----------------
   logic abs_hit;
   assign abs_hit = st_valid_q & st_drop_q; // R1

   logic [paq_pkg::CNT_PKT_W-1:0]  cnt_pkts_q;
   logic [paq_pkg::CNT_BYTE_W-1:0] cnt_bytes_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_pkts_q  <= '0; // R19
         cnt_bytes_q <= '0; // R19
      end else if (abs_hit) begin
         cnt_pkts_q  <= cnt_pkts_q + 1'b1; // R5 R3
         cnt_bytes_q <= cnt_bytes_q
                        + paq_pkg::CNT_BYTE_W'(st_len_q); // R5 R3
      end
   end
   // the dropped packet stops here: no path leads on from abs_hit R2

   assign drop_pkts  = cnt_pkts_q;
   assign drop_bytes = cnt_bytes_q;

   // ---------------- pool storage and tail dropper ----------------
   logic [DATA_W-1:0] mem_data_q [POOL_DEPTH];
   logic [LEN_W-1:0]  mem_len_q  [POOL_DEPTH];
   logic [AW-1:0]     wr_q;
   logic [AW-1:0]     rd_q;
   logic [FW-1:0]     fcnt_q;
   logic [CW-1:0]     dpk_q;
   logic [BW-1:0]     dby_q;
   logic              limit_hit;
   logic              enq;
   logic              tdrop;
   logic              deq;

   // buffer exhaustion or the configured depth refuse the packet
   assign limit_hit = (fcnt_q == FW'(POOL_DEPTH))
                      | (cfg_limit_en & (dpk_q >= cfg_limit_pkts)); // R17 R12
   assign enq   = st_valid_q & ~st_drop_q & ~limit_hit; // R8
   assign tdrop = st_valid_q & ~st_drop_q & limit_hit; // R17

   function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
      return (p == AW'(POOL_DEPTH - 1)) ? '0 : AW'(p + 1'b1);
   endfunction

   always_ff @(posedge clk) begin
      if (enq) begin
         mem_data_q[wr_q] <= st_data_q; // R8
         mem_len_q[wr_q]  <= st_len_q;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_q   <= '0; // R19
         rd_q   <= '0; // R19
         fcnt_q <= '0; // R19
      end else begin
         if (enq) begin
            wr_q <= ptr_inc(wr_q); // R9
         end
         if (deq) begin
            rd_q <= ptr_inc(rd_q); // R9 R13
         end
         fcnt_q <= FW'(fcnt_q + FW'(enq) - FW'(deq)); // R16
      end
   end

   // ---------------- two-entry output buffer ----------------
   logic [DATA_W-1:0] ob_data_q [OB];
   logic [LEN_W-1:0]  ob_len_q  [OB];
   logic [1:0]        ob_cnt_q;
   logic              ob_pop;
   logic [1:0]        ob_wi;
   logic [1:0]        ob_cnt_d;
   logic              out_valid_q;

   assign ob_pop   = out_valid_q & out_ready; // R18
   assign deq      = (fcnt_q != '0)
                     & ((ob_cnt_q < 2'(OB)) | ob_pop); // R8
   assign ob_wi    = 2'(ob_cnt_q - 2'(ob_pop));
   assign ob_cnt_d = 2'(ob_cnt_q + 2'(deq) - 2'(ob_pop));

   always_ff @(posedge clk) begin
      if (ob_pop) begin
         ob_data_q[0] <= ob_data_q[1];
         ob_len_q[0]  <= ob_len_q[1];
      end
      if (deq) begin
         ob_data_q[ob_wi[0]] <= mem_data_q[rd_q]; // R9
         ob_len_q[ob_wi[0]]  <= mem_len_q[rd_q];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ob_cnt_q    <= '0; // R19
         out_valid_q <= paq_pkg::RST_VALID;
      end else begin
         ob_cnt_q    <= ob_cnt_d;
         out_valid_q <= (ob_cnt_d != 2'h0); // R7
      end
   end

   assign out_valid = out_valid_q;
   assign out_data  = ob_data_q[0];
   assign out_len   = ob_len_q[0];

   // ---------------- depth tracking and triggers ----------------
   logic [CW-1:0] dpk_d;
   logic [BW-1:0] dby_d;
   logic          over_pk_q;
   logic          over_by_q;
   logic          avail_q;
   logic          tdrop_q;
   logic [FW-1:0] free_q;
   logic          low_q;
   logic [FW-1:0] free_d;

   // depth counts everything held, pool and output buffer alike
   assign dpk_d  = CW'(dpk_q + CW'(enq) - CW'(ob_pop)); // R10
   assign dby_d  = BW'(dby_q + (enq ? BW'(st_len_q) : '0)
                   - (ob_pop ? BW'(ob_len_q[0]) : '0)); // R10
   assign free_d = FW'(FW'(POOL_DEPTH) - FW'(fcnt_q + FW'(enq) - FW'(deq)));

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dpk_q     <= '0; // R19
         dby_q     <= '0; // R19
         over_pk_q <= paq_pkg::RST_FLAG;
         over_by_q <= paq_pkg::RST_FLAG;
         avail_q   <= paq_pkg::RST_FLAG;
         free_q    <= FW'(POOL_DEPTH); // R19
         low_q     <= paq_pkg::RST_FLAG;
         tdrop_q   <= paq_pkg::RST_FLAG;
      end else begin
         dpk_q     <= dpk_d; // R10
         dby_q     <= dby_d; // R10
         over_pk_q <= (dpk_d >= cfg_thresh_pkts); // R11 R14
         over_by_q <= (dby_d >= cfg_thresh_bytes); // R11 R14
         avail_q   <= (dpk_d != '0); // R15
         free_q    <= free_d; // R16
         low_q     <= (free_d <= cfg_pool_thresh); // R16
         tdrop_q   <= tdrop; // R17
      end
   end

   assign depth_pkts  = dpk_q; // R14
   assign depth_bytes = dby_q; // R14
   assign over_pkts   = over_pk_q;
   assign over_bytes  = over_by_q;
   assign pkts_avail  = avail_q;
   assign pool_free   = free_q;
   assign pool_low    = low_q;
   assign tail_drop   = tdrop_q;

endmodule // paq_queue

/* src/paq_pkg.sv */
// Notes on behaviour
// [R1] absolute dropper discards all, no configuration
// [R2] dropper is a sink, nothing goes downstream
// [R3] dropped packets pass a counter first
// [R4] multiplexor merges many ports, packets unchanged
// [R5] counter forwards unchanged, adds length and one
// [R6] null action passes packet with no effect
// [R7] queue takes many inputs, one output, zero+
// [R8] enqueue at tail, dequeue from head
// [R9] packets leave in arrival order
// [R10] depth in packets and bytes every cycle
// [R11] configurable depth thresholds for neighbours
// [R12] queue has no limit; input dropper limits
// [R13] no reordering of any packet pair
// [R14] depth and triggers exported to droppers
// [R15] packets available while at least one held
// [R16] storage from free pool with threshold
// [R17] discard on exhaustion, threshold or meter; no meter here, only a full pool or the cfg_limit_pkts depth limit
// [R18] transfer only on valid and ready
// [R19] reset empties queue and clears counters
package paq_pkg;

   // default shape of the datapath
   localparam int M_PORTS_DEF    = 4;
   localparam int DATA_W_DEF     = 32;
   localparam int LEN_W_DEF      = 16;
   localparam int POOL_DEPTH_DEF = 16;

   // statistics counter widths
   localparam int CNT_PKT_W  = 32;
   localparam int CNT_BYTE_W = 48;

   // output buffer entries
   localparam int OBUF_ENTRIES = 2;

   // reset values
   localparam logic RST_VALID = 1'h0;
   localparam logic RST_FLAG  = 1'h0;

endpackage

/* bench/paq_sched_model.sv */
`timescale 1ns/1ps
module paq_sched_model (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic [1:0] mode,
   output logic            out_ready
);
   logic tog_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) tog_q <= 1'h0;
      else tog_q <= ~tog_q;
   end
   // mode 0 takes every head, 1 every other cycle, 2 stalls
   assign out_ready = (mode == 2'h0) || (mode == 2'h1 && tog_q);
endmodule // paq_sched_model

/* bench/paq_queue_chk.sv */
`timescale 1ns/1ps
module paq_queue_chk #(
   parameter int M_PORTS = 4,
   parameter int DATA_W  = 32,
   parameter int LEN_W   = 16,
   parameter int CW      = 5
) (
   input wire logic                         clk,
   input wire logic                         rst_n,
   input wire logic [M_PORTS-1:0]           in_valid,
   input wire logic [M_PORTS-1:0]           in_ready,
   input wire logic [M_PORTS-1:0]           in_drop,
   input wire logic                         out_valid,
   input wire logic                         out_ready,
   input wire logic [DATA_W-1:0]            out_data,
   input wire logic [LEN_W-1:0]             out_len,
   input wire logic [CW-1:0]                depth_pkts,
   input wire logic                         pkts_avail,
   input wire logic [paq_pkg::CNT_PKT_W-1:0] drop_pkts
);
   wire logic tk_drop = |(in_valid & in_ready & in_drop);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_av; pkts_avail == (depth_pkts != '0);
   endproperty
   a_av: assert property (p_av) else $error("avail vs depth");
   property p_oh; $onehot0(in_ready);
   endproperty
   a_oh: assert property (p_oh) else $error("grant not onehot");
   property p_hold; out_valid && !out_ready |=>
      out_valid && $stable(out_data) && $stable(out_len);
   endproperty
   a_hold: assert property (p_hold) else $error("head moved");
   property p_step; depth_pkts == $past(depth_pkts) ||
      depth_pkts == $past(depth_pkts) + 1 ||
      depth_pkts == $past(depth_pkts) - 1;
   endproperty
   a_step: assert property (p_step) else $error("depth jump");
   property p_empty; depth_pkts == '0 |-> !out_valid;
   endproperty
   a_empty: assert property (p_empty) else $error("out while empty");
   property p_dinc; tk_drop |-> ##2 drop_pkts == $past(drop_pkts) + 1;
   endproperty
   a_dinc: assert property (p_dinc) else $error("drop not counted");
   property p_didle; !tk_drop |-> ##2 drop_pkts == $past(drop_pkts);
   endproperty
   a_didle: assert property (p_didle) else $error("drop miscount");
   property p_rst; $rose(rst_n) |-> in_ready == '0 && !out_valid &&
      depth_pkts == '0 && drop_pkts == '0;
   endproperty
   a_rst: assert property (p_rst) else $error("reset state");
endmodule // paq_queue_chk
bind paq_queue paq_queue_chk #(.M_PORTS(M_PORTS), .DATA_W(DATA_W),
   .LEN_W(LEN_W), .CW(CW)) u_chk (.clk(clk), .rst_n(rst_n),
   .in_valid(in_valid), .in_ready(in_ready), .in_drop(in_drop),
   .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
   .out_len(out_len), .depth_pkts(depth_pkts), .pkts_avail(pkts_avail),
   .drop_pkts(drop_pkts));

/* bench/paq_queue_tb_top.sv */
`timescale 1ns/1ps
module paq_queue_tb_top;
   logic        clk = 1'h0, rst_n = 1'h0, lim_en = 1'h0;
   logic [3:0]  in_valid = 4'h0, in_drop = 4'h0;
   logic [127:0] in_data = '0;
   logic [63:0] in_len = '0;
   logic [4:0]  lim = 5'h0;
   logic [1:0]  mode = 2'h0;
   wire logic [3:0] in_ready;
   wire logic   out_valid, out_ready, ov_p, ov_b, pool_low, pkts_avail, tdrop;
   wire logic [31:0] out_data, drop_pkts;
   wire logic [15:0] out_len;
   wire logic [4:0] depth_pkts, pool_free;
   wire logic [20:0] depth_bytes;
   wire logic [47:0] drop_bytes;
   logic [47:0] exp_q[$];
   logic [47:0] e_db = '0;
   int          errors = 0, n_compared = 0, n_tail = 0, seq = 0, e_dp = 0;
   always #4 clk = ~clk;
   paq_queue DUT (.clk(clk), .rst_n(rst_n), .in_valid(in_valid),
      .in_ready(in_ready), .in_data(in_data), .in_len(in_len),
      .in_drop(in_drop), .out_valid(out_valid), .out_ready(out_ready),
      .out_data(out_data), .out_len(out_len), .cfg_limit_en(lim_en),
      .cfg_limit_pkts(lim), .cfg_thresh_pkts(5'h08),
      .cfg_thresh_bytes(21'h000080), .cfg_pool_thresh(5'h02),
      .depth_pkts(depth_pkts), .depth_bytes(depth_bytes), .over_pkts(ov_p),
      .over_bytes(ov_b), .pool_free(pool_free), .pool_low(pool_low),
      .pkts_avail(pkts_avail), .tail_drop(tdrop), .drop_pkts(drop_pkts),
      .drop_bytes(drop_bytes));
   paq_sched_model u_sched (.clk(clk), .rst_n(rst_n), .mode(mode),
      .out_ready(out_ready));
   task tally_and_finish;
      $display("counts: %0d compared, %0d errors", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task chk(input string nm, input logic [47:0] e, input logic [47:0] s);
      n_compared++;
      if (e !== s) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask
   always @(posedge clk) begin
      if (rst_n === 1'h1 && tdrop === 1'h1) n_tail++;
      if (rst_n === 1'h1 && out_valid === 1'h1 && out_ready === 1'h1) begin
         if (exp_q.size() == 0) chk("stray out", '1, {out_len, out_data});
         else chk("out pkt", exp_q.pop_front(), {out_len, out_data});
      end
   end
   task push(input logic [3:0] m, input logic [3:0] dm, input logic keep);
      logic [3:0] g;
      int i, k;
      seq++;
      for (i = 0; i < 4; i++) begin
         in_data[i*32 +: 32] = 32'ha500_0000 | 32'(seq << 4) | 32'(i);
         in_len[i*16 +: 16] = 16'h0020 + 16'(seq + i);
      end
      in_drop = dm;
      in_valid = m;
      for (k = 0; k < 40 && in_valid != 4'h0; k++) begin
         @(posedge clk);
         g = in_valid & in_ready;
         for (i = 0; i < 4; i++) if (g[i] === 1'h1) begin
            if (dm[i]) e_dp++;
            if (dm[i]) e_db += 48'(in_len[i*16 +: 16]);
            else if (keep) exp_q.push_back({in_len[i*16 +: 16], in_data[i*32 +: 32]});
         end
         #1 in_valid = in_valid & ~g;
      end
      if (in_valid != 4'h0) begin errors++; tally_and_finish(); end
   endtask
   task drain;
      int k;
      for (k = 0; k < 300 && (exp_q.size() != 0 || depth_pkts !== 5'h0); k++)
         @(posedge clk);
      #1;
      if (k == 300) begin errors++; tally_and_finish(); end
   endtask
   task t_mux;
      push(4'hf, 4'h0, 1'h1);
      drain();
      chk("avail empty", 48'h0, 48'(pkts_avail));
      $display("t_mux done");
   endtask
   task t_drop;
      push(4'hf, 4'h5, 1'h1);
      repeat (4) @(posedge clk);
      #1;
      chk("drop pkts", 48'(e_dp), 48'(drop_pkts));
      chk("drop bytes", e_db, drop_bytes);
      drain();
      $display("t_drop done");
   endtask
   task t_cap(input int n, input logic le, input int lv, input int nk);
      int j, t0, b, q;
      mode = 2'h2;
      lim_en = le;
      lim = 5'(lv);
      t0 = n_tail;
      for (j = 0; j < n; j++) begin
         push(4'h1, 4'h0, j < nk);
         repeat (3) @(posedge clk);
         #1;
      end
      chk("depth", 48'(nk), 48'(depth_pkts));
      chk("avail", 48'h1, 48'(pkts_avail));
      chk("tail drops", 48'(n - nk), 48'(n_tail - t0));
      chk("over pkts", 48'(nk >= 8), 48'(ov_p));
      b = 0;
      for (q = 0; q < exp_q.size(); q++) b += int'(exp_q[q][47:32]);
      chk("depth bytes", 48'(b), 48'(depth_bytes));
      chk("over bytes", 48'(b >= 128), 48'(ov_b));
      chk("pool free", 48'(18 - nk), 48'(pool_free));
      chk("pool low", 48'(18 - nk <= 2), 48'(pool_low));
      mode = 2'h1;
      drain();
      lim_en = 1'h0;
      chk("pool back", 48'h10, 48'(pool_free));
      $display("t_cap done");
   endtask
   task t_rst;
      mode = 2'h2;
      push(4'h3, 4'h1, 1'h0);
      repeat (3) @(posedge clk);
      #1 rst_n = 1'h0;
      exp_q.delete();
      @(posedge clk);
      #1;
      chk("rst depth", 48'h0, 48'(depth_pkts));
      chk("rst drops", 48'h0, 48'(drop_pkts));
      chk("rst pool", 48'h10, 48'(pool_free));
      rst_n = 1'h1;
      mode = 2'h0;
      e_dp = 0;
      e_db = '0;
      $display("t_rst done");
   endtask
   initial begin
      repeat (3) @(posedge clk);
      #1 rst_n = 1'h1;
      t_mux();
      t_drop();
      t_cap(20, 1'h0, 0, 18);
      t_cap(6, 1'h1, 3, 3);
      t_rst();
      t_drop();
      tally_and_finish();
   end
endmodule // paq_queue_tb_top
